// [logic/brk_unit_map.vh]
// register offsets, field positions, reset values of the breakpoint unit
// assumes a plain register port with 3-bit word addresses, 8-bit data
//
// Overview of operation
// - address match raises break request to cpu
// - match on last cycle breaks immediately
// - active flag set on address match
// - writing one to active flag forces break
// - software clears active flag; reset clears it
// - enable bit 7 permits address breaks
// - address high and low bytes reset zero
// - all timer counters halt during break
// - watchdog off in break with test voltage
// - flag clearing in break needs clear enable
// - unit stays working in wait mode
// - break exits stop and sets wake flag
// - wake flag cleared by writing zero, reset
// - compare only cpu program counter addresses
`ifndef BRK_UNIT_MAP_VH
`define BRK_UNIT_MAP_VH

// ----------------------------------------------------------------------
// register word addresses
// ----------------------------------------------------------------------
`define BRK_ADDR_CTRL     3'h0
`define BRK_ADDR_HIGH     3'h1
`define BRK_ADDR_LOW      3'h2
`define BRK_ADDR_WAKE     3'h3
`define BRK_ADDR_FLAGCTL  3'h4
`define BRK_ADDR_IRQ_STAT 3'h5
`define BRK_ADDR_IRQ_MASK 3'h6

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define BRK_BIT_ENABLE    7
`define BRK_BIT_ACTIVE    6
`define BRK_BIT_WAKE      1
`define BRK_BIT_CLR_EN    7
`define BRK_IRQ_BREAK     0
`define BRK_IRQ_WAKE      1
`define BRK_RST_BYTE      8'h00

`endif

// [logic/brk_sync3.v]
// three-stage input synchroniser for a level from another domain
// assumes one clock; output changes when stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module brk_sync3
(
  input  wire clk_i,
  input  wire rst_b_i,
  input  wire d_i,
  output reg  q_o
);

  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  // ----------------------------------------------------------------------
  // shift chain; the first stage feeds only the second
  // ----------------------------------------------------------------------
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      q_o    <= 1'b0;
    end
    else
    begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        q_o <= s3_reg; // agreement filters a single glitchy sample
    end
  end

endmodule // brk_sync3

`default_nettype wire

// [logic/brk_unit.v]
// address breakpoint unit: compare, break flags, wake flag, freezes
// assumes the cpu core honours break_req_o and pulses rti/stop/wait
`timescale 1ns/1ps
`default_nettype none
`include "brk_unit_map.vh"

module brk_unit
(
  input  wire       clk_i,
  input  wire       rst_b_i,
  // register port
  input  wire [2:0] reg_addr_i,
  input  wire [7:0] reg_wdata_i,
  input  wire       reg_wr_i,
  input  wire       reg_rd_i,
  output reg  [7:0] reg_rdata_o,
  // cpu side
  input  wire [15:0] cpu_addr_i,
  input  wire       cpu_addr_valid_i,
  input  wire       cpu_last_cycle_i,
  input  wire       cpu_rti_i,
  input  wire       cpu_in_wait_i,
  input  wire       cpu_in_stop_i,
  input  wire       test_high_voltage_i,
  input  wire       status_clear_req_i,
  output reg        break_req_o,
  output reg        break_now_o,
  output reg        in_break_o,
  output reg        stop_exit_o,
  output reg        timer_freeze_o,
  output reg        watchdog_disable_o,
  output reg        status_clear_ok_o,
  output reg        irq_o
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  reg        breakpoint_enable_reg;
  reg        break_active_flag_reg;
  reg [7:0]  breakpoint_address_high_reg;
  reg [7:0]  breakpoint_address_low_reg;
  reg        wake_by_break_flag_reg;
  reg        flag_clear_in_break_enable_reg;
  reg [1:0]  irq_stat_reg;
  reg [1:0]  irq_mask_reg;
  reg        in_break_reg;
  reg        pending_reg;
  wire       thv_sync;

  // test high voltage arrives from the reset pin, another domain
  brk_sync3 u_thv_sync
  (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .d_i     (test_high_voltage_i),
    .q_o     (thv_sync)
  );

  // ----------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------
  function wr_hit;
    input [2:0] a;
    input [2:0] target;
    input       wr;
    begin
      wr_hit = wr && (a == target);
    end
  endfunction

  wire wr_ctrl  = wr_hit(reg_addr_i, `BRK_ADDR_CTRL, reg_wr_i);
  wire wr_high  = wr_hit(reg_addr_i, `BRK_ADDR_HIGH, reg_wr_i);
  wire wr_low   = wr_hit(reg_addr_i, `BRK_ADDR_LOW, reg_wr_i);
  wire wr_wake  = wr_hit(reg_addr_i, `BRK_ADDR_WAKE, reg_wr_i);
  wire wr_fctl  = wr_hit(reg_addr_i, `BRK_ADDR_FLAGCTL, reg_wr_i);
  wire wr_istat = wr_hit(reg_addr_i, `BRK_ADDR_IRQ_STAT, reg_wr_i);
  wire wr_imask = wr_hit(reg_addr_i, `BRK_ADDR_IRQ_MASK, reg_wr_i);

  // only program counter addresses are compared, not dma or others
  wire addr_match = cpu_addr_valid_i &&
    (cpu_addr_i == {breakpoint_address_high_reg,
                    breakpoint_address_low_reg});
  wire match_ok = addr_match && breakpoint_enable_reg;
  // a one written to the active flag forces a break with no match
  wire sw_break = wr_ctrl && reg_wdata_i[`BRK_BIT_ACTIVE];
  wire break_evt = match_ok || sw_break;
  // wait mode keeps this logic clocked, so matches still count
  wire wake_evt = break_evt && (cpu_in_wait_i || cpu_in_stop_i);

  // ----------------------------------------------------------------------
  // control and address registers
  // ----------------------------------------------------------------------
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      breakpoint_enable_reg          <= 1'b0;
      breakpoint_address_high_reg    <= `BRK_RST_BYTE;
      breakpoint_address_low_reg     <= `BRK_RST_BYTE;
      flag_clear_in_break_enable_reg <= 1'b0;
      irq_mask_reg                   <= 2'h0;
    end
    else
    begin
      if (wr_ctrl)
        breakpoint_enable_reg <= reg_wdata_i[`BRK_BIT_ENABLE];
      if (wr_high)
        breakpoint_address_high_reg <= reg_wdata_i;
      if (wr_low)
        breakpoint_address_low_reg <= reg_wdata_i;
      if (wr_fctl)
        flag_clear_in_break_enable_reg <= reg_wdata_i[`BRK_BIT_CLR_EN];
      if (wr_imask)
        irq_mask_reg <= reg_wdata_i[1:0];
    end
  end

  // ----------------------------------------------------------------------
  // sticky flags; a hardware set beats a same-cycle software clear
  // ----------------------------------------------------------------------
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      break_active_flag_reg  <= 1'b0;
      wake_by_break_flag_reg <= 1'b0;
      irq_stat_reg           <= 2'h0;
    end
    else
    begin
      if (break_evt)
        break_active_flag_reg <= 1'b1;
      else if (wr_ctrl && !reg_wdata_i[`BRK_BIT_ACTIVE])
        break_active_flag_reg <= 1'b0;
      if (wake_evt)
        wake_by_break_flag_reg <= 1'b1;
      else if (wr_wake && !reg_wdata_i[`BRK_BIT_WAKE])
        wake_by_break_flag_reg <= 1'b0;
      irq_stat_reg[`BRK_IRQ_BREAK] <= break_evt ||
        (irq_stat_reg[`BRK_IRQ_BREAK] &&
         !(wr_istat && reg_wdata_i[`BRK_IRQ_BREAK]));
      irq_stat_reg[`BRK_IRQ_WAKE] <= wake_evt ||
        (irq_stat_reg[`BRK_IRQ_WAKE] &&
         !(wr_istat && reg_wdata_i[`BRK_IRQ_WAKE]));
    end
  end

  // ----------------------------------------------------------------------
  // break state: request held until the cpu takes it, left on rti
  // ----------------------------------------------------------------------
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pending_reg  <= 1'b0;
      in_break_reg <= 1'b0;
    end
    else
    begin
      if (cpu_rti_i && in_break_reg)
      begin
        in_break_reg <= 1'b0;
        pending_reg  <= 1'b0;
      end
      else if (pending_reg && cpu_last_cycle_i)
      begin
        pending_reg  <= 1'b0;
        in_break_reg <= 1'b1;
      end
      else if (break_evt && !in_break_reg)
      begin
        if (cpu_last_cycle_i)
          in_break_reg <= 1'b1;
        else
          pending_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // registered outputs to the cpu and neighbouring blocks
  // ----------------------------------------------------------------------
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      break_req_o        <= 1'b0;
      break_now_o        <= 1'b0;
      in_break_o         <= 1'b0;
      stop_exit_o        <= 1'b0;
      timer_freeze_o     <= 1'b0;
      watchdog_disable_o <= 1'b0;
      status_clear_ok_o  <= 1'b0;
      irq_o              <= 1'b0;
    end
    else
    begin
      // level request; cpu vectors per its own mode
      break_req_o <= (pending_reg || (break_evt && !in_break_reg)) &&
                     !(cpu_rti_i && in_break_reg);
      // one-cycle pulse when a match lands on the last cycle
      break_now_o <= break_evt && !in_break_reg && !pending_reg &&
                     cpu_last_cycle_i;
      in_break_o <= in_break_reg;
      stop_exit_o <= break_evt && cpu_in_stop_i;
      timer_freeze_o <= in_break_reg;
      watchdog_disable_o <= in_break_reg && thv_sync;
      // outside a break clearing is always allowed
      status_clear_ok_o <= status_clear_req_i &&
        (!in_break_reg || flag_clear_in_break_enable_reg);
      irq_o <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ----------------------------------------------------------------------
  // read data, one cycle after the strobe; unmapped reads zero
  // ----------------------------------------------------------------------
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        `BRK_ADDR_CTRL:
          reg_rdata_o <= {breakpoint_enable_reg, break_active_flag_reg,
                          6'h00};
        `BRK_ADDR_HIGH:     reg_rdata_o <= breakpoint_address_high_reg;
        `BRK_ADDR_LOW:      reg_rdata_o <= breakpoint_address_low_reg;
        `BRK_ADDR_WAKE:
          reg_rdata_o <= {6'h00, wake_by_break_flag_reg, 1'b0};
        `BRK_ADDR_FLAGCTL:
          reg_rdata_o <= {flag_clear_in_break_enable_reg, 7'h00};
        `BRK_ADDR_IRQ_STAT: reg_rdata_o <= {6'h00, irq_stat_reg};
        `BRK_ADDR_IRQ_MASK: reg_rdata_o <= {6'h00, irq_mask_reg};
        default:            reg_rdata_o <= 8'h00;
      endcase
    end
    else
      reg_rdata_o <= 8'h00;
  end

endmodule // brk_unit

`default_nettype wire

// [verification/brk_unit_checker.sv]
// checker: port-level timing of the breakpoint unit
// assumes bind onto brk_unit; one clock, async active-low reset
`timescale 1ns/1ps
`default_nettype none
module brk_unit_checker
(
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  input wire logic [2:0]  reg_addr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic [15:0] cpu_addr_i,
  input wire logic        cpu_addr_valid_i,
  input wire logic        cpu_last_cycle_i,
  input wire logic        cpu_rti_i,
  input wire logic        cpu_in_stop_i,
  input wire logic        test_high_voltage_i,
  input wire logic        status_clear_req_i,
  input wire logic        break_req_o,
  input wire logic        break_now_o,
  input wire logic        in_break_o,
  input wire logic        stop_exit_o,
  input wire logic        timer_freeze_o,
  input wire logic        watchdog_disable_o,
  input wire logic        status_clear_ok_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic [15:0] bp_reg;
  logic        en_reg;
  // shadow of enable and address bytes, seen from the write port
  always_ff @(posedge clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      bp_reg <= 16'h0000;
      en_reg <= 1'b0;
    end
    else if (reg_wr_i)
      case (reg_addr_i)
        3'h0: en_reg <= reg_wdata_i[7];
        3'h1: bp_reg[15:8] <= reg_wdata_i;
        3'h2: bp_reg[7:0] <= reg_wdata_i;
        default: ;
      endcase
  // events; in_break_o one cycle on shows the state the event met
  wire hit = en_reg && cpu_addr_valid_i && cpu_addr_i == bp_reg;
  wire sw_ev = reg_wr_i && reg_addr_i == 3'h0 && reg_wdata_i[6];
  sequence s_free(c); c ##1 !in_break_o; endsequence
  property p_req; s_free(hit && !cpu_last_cycle_i && !cpu_rti_i)
    |-> break_req_o; endproperty
  a_req: assert property (p_req) else $error("no request");
  property p_now; s_free(hit && cpu_last_cycle_i && !cpu_rti_i
    && !break_req_o) |-> ##[0:1] break_now_o; endproperty
  a_now: assert property (p_now) else $error("no immediate");
  property p_ignore; !break_req_o && !hit && !sw_ev |=> !break_req_o;
  endproperty
  a_ignore: assert property (p_ignore) else $error("stray");
  property p_freeze; timer_freeze_o == in_break_o; endproperty
  a_freeze: assert property (p_freeze) else $error("freeze");
  property p_wd_off; !test_high_voltage_i [*6] |-> !watchdog_disable_o;
  endproperty
  a_wd_off: assert property (p_wd_off) else $error("wd off");
  property p_wd_on; test_high_voltage_i [*6] ##0 in_break_o
    |-> watchdog_disable_o; endproperty
  a_wd_on: assert property (p_wd_on) else $error("wd on");
  property p_clr; s_free(status_clear_req_i) |-> status_clear_ok_o;
  endproperty
  a_clr: assert property (p_clr) else $error("clear gate");
  property p_stop; s_free(sw_ev && cpu_in_stop_i) |-> ##[0:1] stop_exit_o;
  endproperty
  a_stop: assert property (p_stop) else $error("stop exit");
endmodule // brk_unit_checker
bind brk_unit brk_unit_checker u_chk (.*);
`default_nettype wire

// [verification/brk_cpu_model.sv]
// cpu core stand-in: instruction-end marker and break return
// assumes in_break_i from brk_unit; the bench steers slow_i and hold_i
`timescale 1ns/1ps
`default_nettype none
module brk_cpu_model
(
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic in_break_i,
  input  wire logic slow_i,
  input  wire logic hold_i,
  output wire logic last_cycle_o,
  output var  logic rti_o
);
  logic [1:0] cnt_reg;
  logic       sent_reg;
  // instructions end every cycle, or every fourth to leave a pending gap
  assign last_cycle_o = !slow_i || cnt_reg == 2'h3;
  // one return pulse per break; hold keeps the routine running
  always_ff @(posedge clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      cnt_reg <= 2'h0;
      rti_o <= 1'b0;
      sent_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_reg + 2'h1;
      // vector choice and return rewind are the routine's concern
      rti_o <= in_break_i && !hold_i && !rti_o && !sent_reg;
      sent_reg <= in_break_i && (sent_reg || rti_o);
    end
endmodule // brk_cpu_model
`default_nettype wire

// [verification/brk_unit_test.sv]
// bench: register port and cpu-side scenarios for the breakpoint unit
// assumes brk_unit, brk_cpu_model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module brk_unit_test;
  logic clk_i = 1'b0, rst_b_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [2:0] reg_addr_i = 3'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [15:0] cpu_addr_i = 16'h0000;
  logic cpu_addr_valid_i = 1'b0, cpu_in_wait_i = 1'b0, cpu_in_stop_i = 1'b0;
  logic test_high_voltage_i = 1'b0, status_clear_req_i = 1'b0;
  logic slow = 1'b1, hold = 1'b1;
  int   n_fail = 0, check_count = 0;
  wire logic [7:0] reg_rdata_o;
  wire logic cpu_last_cycle_i, cpu_rti_i, break_req_o, break_now_o;
  wire logic in_break_o, stop_exit_o, timer_freeze_o, watchdog_disable_o;
  wire logic status_clear_ok_o, irq_o;
  brk_unit DUT (.*);
  brk_cpu_model CPU (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .in_break_i(in_break_o), .slow_i(slow), .hold_i(hold),
    .last_cycle_o(cpu_last_cycle_i), .rti_o(cpu_rti_i));
  always #5 clk_i = ~clk_i;
  // --------------------------------------------------------------
  // access tasks
  // --------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, e);
  endtask
  // bounded wait on the break state; running out ends the run
  task automatic wait_brk(input logic v);
    int n;
    for (n = 0; n < 40 && in_break_o !== v; n++)
      @(posedge clk_i) #1;
    chk({7'h0, in_break_o}, {7'h0, v});
    if (n == 40)
      print_verdict();
  endtask
  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    for (int a = 0; a < 8; a++)
      rd(a[2:0], 8'h00);
    $display("test reset done");
    wr(3'h1, 8'h5a);
    wr(3'h2, 8'h3c);
    rd(3'h1, 8'h5a);
    rd(3'h2, 8'h3c);
    @(posedge clk_i);
    cpu_addr_i <= 16'h5a3c;
    cpu_addr_valid_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    cpu_addr_valid_i <= 1'b0;
    #1 chk({7'h0, break_req_o}, 8'h00);
    rd(3'h0, 8'h00);
    wr(3'h0, 8'h80);
    rd(3'h0, 8'h80);
    repeat (4) @(posedge clk_i);
    #1 chk({7'h0, break_req_o}, 8'h00);
    $display("test ignore done");
    @(posedge clk_i);
    cpu_addr_valid_i <= 1'b1;
    status_clear_req_i <= 1'b1;
    wait_brk(1'b1);
    rd(3'h0, 8'hc0);
    chk({7'h0, timer_freeze_o}, 8'h01);
    chk({7'h0, status_clear_ok_o}, 8'h00);
    wr(3'h4, 8'h80);
    @(posedge clk_i) #1 chk({7'h0, status_clear_ok_o}, 8'h01);
    test_high_voltage_i <= 1'b1;
    cpu_addr_valid_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    #1 chk({7'h0, watchdog_disable_o}, 8'h01);
    wr(3'h0, 8'h80);
    rd(3'h0, 8'h80);
    @(posedge clk_i);
    test_high_voltage_i <= 1'b0;
    hold <= 1'b0;
    wait_brk(1'b0);
    chk({7'h0, timer_freeze_o}, 8'h00);
    hold <= 1'b1;
    $display("test match done");
    wr(3'h0, 8'h00);
    cpu_in_stop_i <= 1'b1;
    wr(3'h0, 8'h40);
    #1 chk({7'h0, stop_exit_o}, 8'h01);
    wait_brk(1'b1);
    rd(3'h3, 8'h02);
    wr(3'h3, 8'h00);
    rd(3'h3, 8'h00);
    cpu_in_stop_i <= 1'b0;
    hold <= 1'b0;
    wait_brk(1'b0);
    hold <= 1'b1;
    $display("test force done");
    slow <= 1'b0;
    cpu_in_wait_i <= 1'b1;
    wr(3'h0, 8'h80);
    cpu_addr_valid_i <= 1'b1;
    @(posedge clk_i) #1 chk({7'h0, break_now_o}, 8'h01);
    wait_brk(1'b1);
    cpu_addr_valid_i <= 1'b0;
    cpu_in_wait_i <= 1'b0;
    rd(3'h3, 8'h02);
    rd(3'h5, 8'h03);
    chk({7'h0, irq_o}, 8'h00);
    wr(3'h6, 8'h03);
    @(posedge clk_i) #1 chk({7'h0, irq_o}, 8'h01);
    wr(3'h5, 8'h03);
    rd(3'h5, 8'h00);
    chk({7'h0, irq_o}, 8'h00);
    $display("test wait and irq done");
    print_verdict();
  end
endmodule // brk_unit_test
`default_nettype wire
